// [verilog/oms_pkg.sv]
// Package with the constants and types of the operating mode select block.
package oms_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] MODE_CONTROL_ADDR = 12'h000;
  localparam int          EXT_BIT           = 7;
  localparam int          RESV_HI           = 6;
  localparam int          RESV_LO           = 3;
  localparam logic [3:0]  RESV_VALUE        = 4'h0;
  localparam logic        EXT_RESET         = 1'h0;
  localparam logic [31:0] RDATA_IDLE        = 32'h0000_0000;

  // ----------------------------------------
  // Mode pin encodings
  // ----------------------------------------
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_6 = 3'h6;
  localparam logic [2:0] MODE_7 = 3'h7;

  // CPU addressing style.
  typedef enum logic [1:0] {
    OMS_CPU_NORMAL,
    OMS_CPU_ADVANCED,
    OMS_CPU_EMULATION
  } oms_cpu_type;

  // Decoded operating mode as seen by the rest of the chip.
  typedef struct packed {
    oms_cpu_type cpu_mode;
    logic        rom_enabled;
    logic        expansion;
    logic        single_chip;
    logic        emulation;
    logic        unsupported;
  } oms_mode_type;

  // Three mode pin levels, highest pin in bit 2.
  typedef struct packed {
    logic hi;
    logic mid;
    logic lo;
  } oms_pins_type;

endpackage

// [verilog/oms_top.sv]
// Operating mode select: mode pin decode and mode control register on APB.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
// Function
// - Mode 1: advanced, ROM off, expansion on
// - Modes 2/3: ROM on, advanced/normal addressing
// - Modes 6/7: emulation with ROM on
// - Reduced pins: top pin forced to zero
// - Mode 1: extended enable reads one, fixed
// - Modes 2/3: extended enable writable, resets zero
// - Bits 6 to 3 read zero, ignored
// - Bits 2..0 report mode pins, read-only
// - Pin levels latched when register is read
// - After reset status loads from pins

// The block decodes the three strap pins into the operating mode of the chip and
// offers one eight-bit mode control register in the low byte of word zero on APB.
// The decode runs from the latched status bits, so the mode seen by the chip only
// moves at reset, on a read of the register or, for expansion and single-chip, on an enable write; a board that moves its
// straps in operation is not followed until the next read.
// The slave never inserts wait states: a read is answered in the access cycle
// with data captured at the setup edge, and a write lands at the access edge.
// Unmapped words answer with an error and have no side effect.
// The extended enable is only writable in modes 2 and 3; in the emulation modes
// it keeps its stored value, which is zero after reset.
module oms_top (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Board straps.
  input  wire oms_pkg::oms_pins_type mode_pins,
  input  wire logic                  reduced_pins,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Decoded operating mode.
  output oms_pkg::oms_mode_type      mode_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Register state and the next values that feed it.
  oms_pkg::oms_pins_type mode_status;
  oms_pkg::oms_pins_type next_mode_status;
  logic                  extended_enable;
  logic                  next_extended_enable;
  logic [31:0]           next_prdata;
  oms_pkg::oms_mode_type next_mode_out;

  // Combinational helpers; none of these hold state.
  oms_pkg::oms_pins_type pins_eff;
  logic                  hit;
  logic                  setup_read;
  logic                  access_write;
  logic                  is_mode1;
  logic                  is_mode23;
  logic                  ext_read;
  logic [7:0]            reg_view;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------

  // A missing top pin is seen as low so that a floating pad cannot select emulation.
  always_comb begin
    pins_eff    = mode_pins;
    pins_eff.hi = mode_pins.hi & ~reduced_pins;
  end

  // The slave never waits; unmapped addresses answer with an error.
  assign hit          = (paddr == oms_pkg::MODE_CONTROL_ADDR);
  assign setup_read   = psel & ~penable & ~pwrite & hit;
  assign access_write = psel & penable & pwrite & hit;
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~hit;

  // Mode flags come from the latched status, not the raw pins.
  assign is_mode1  = (mode_status == oms_pkg::MODE_1);
  assign is_mode23 = (mode_status == oms_pkg::MODE_2) |
                     (mode_status == oms_pkg::MODE_3);

  // Mode 1 always reports extended operation whatever was written.
  assign ext_read = is_mode1 | extended_enable;

  // Register view used by a read; status bits are refreshed from the pins in the same cycle.
  always_comb begin
    reg_view                                = 8'h00;
    reg_view[oms_pkg::EXT_BIT]              = ext_read;
    reg_view[oms_pkg::RESV_HI:oms_pkg::RESV_LO] = oms_pkg::RESV_VALUE;
    reg_view[2:0]                           = pins_eff;
  end

  // ----------------------------------------
  // Mode control register
  // ----------------------------------------

  // Next values of the register state.
  always_comb begin
    next_mode_status     = mode_status;
    next_extended_enable = extended_enable;
    next_prdata          = oms_pkg::RDATA_IDLE;
    // Reset reloads the status from the pins on every edge while it is held.
    if (reset) begin
      next_mode_status     = pins_eff;
      next_extended_enable = oms_pkg::EXT_RESET;
    end else begin
      // A read captures the pins at the setup edge; the access cycle shows them.
      if (setup_read) begin
        next_mode_status = pins_eff;
        next_prdata      = {24'h000000, reg_view};
      end
      // Only the enable bit is writable, and only in modes 2 and 3.
      if (access_write && is_mode23) begin
        next_extended_enable = pwdata[oms_pkg::EXT_BIT];
      end
    end
  end

  // Register stage; reset is handled in the next-value logic above.
  always_ff @(posedge clk) begin
    mode_status     <= next_mode_status;
    extended_enable <= next_extended_enable;
    prdata          <= next_prdata;
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------

  // Unsupported combinations fall back to a safe ROM-off, no-expansion state.
  always_comb begin
    next_mode_out             = '0;
    next_mode_out.cpu_mode    = oms_pkg::OMS_CPU_NORMAL;
    case (mode_status)
      oms_pkg::MODE_1: begin
        next_mode_out.cpu_mode  = oms_pkg::OMS_CPU_ADVANCED;
        next_mode_out.expansion = 1'b1;
      end
      oms_pkg::MODE_2: begin
        next_mode_out.cpu_mode    = oms_pkg::OMS_CPU_ADVANCED;
        next_mode_out.rom_enabled = 1'b1;
        next_mode_out.expansion   = extended_enable;
        next_mode_out.single_chip = ~extended_enable;
      end
      oms_pkg::MODE_3: begin
        next_mode_out.cpu_mode    = oms_pkg::OMS_CPU_NORMAL;
        next_mode_out.rom_enabled = 1'b1;
        next_mode_out.expansion   = extended_enable;
        next_mode_out.single_chip = ~extended_enable;
      end
      oms_pkg::MODE_6, oms_pkg::MODE_7: begin
        next_mode_out.cpu_mode    = oms_pkg::OMS_CPU_EMULATION;
        next_mode_out.rom_enabled = 1'b1;
        next_mode_out.emulation   = 1'b1;
      end
      default: begin
        next_mode_out.unsupported = 1'b1;
      end
    endcase
    // Reset wins over the decode so that the chip starts in a quiet state.
    if (reset) begin
      next_mode_out             = '0;
      next_mode_out.cpu_mode    = oms_pkg::OMS_CPU_NORMAL;
    end
  end

  // The decoded mode is registered so that the chip sees clean levels.
  always_ff @(posedge clk) begin
    mode_out <= next_mode_out;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Decode assertions
  // ----------------------------------------

  // Mode 1 runs without ROM, with expansion and never as an emulator.
  a_mode1_map: assert property (
    (mode_status == oms_pkg::MODE_1) && $stable(mode_status) |=>
      mode_out.cpu_mode == oms_pkg::OMS_CPU_ADVANCED && !mode_out.rom_enabled &&
      mode_out.expansion && !mode_out.emulation)
    else $error("mode 1 decode wrong");

  // Mode 1 is never reported as single-chip or unsupported.
  a_mode1_single: assert property (
    is_mode1 && $stable(mode_status) |=> !mode_out.single_chip && !mode_out.unsupported)
    else $error("mode 1 flags wrong");

  // Modes 2 and 3 differ only in the addressing style; expansion follows the enable.
  a_mode23_rom: assert property (
    is_mode23 && $stable(mode_status) |=> mode_out.rom_enabled &&
      (mode_out.cpu_mode == ($past(mode_status) == oms_pkg::MODE_2 ?
       oms_pkg::OMS_CPU_ADVANCED : oms_pkg::OMS_CPU_NORMAL)) &&
      (mode_out.expansion == $past(extended_enable)))
    else $error("mode 2/3 decode wrong");

  // Single-chip and expansion are exact opposites in modes 2 and 3.
  a_single_xor: assert property (
    is_mode23 && $stable(mode_status) |=> mode_out.single_chip != mode_out.expansion)
    else $error("single-chip and expansion agree");

  // Both emulation modes keep the ROM on.
  a_emul_map: assert property (
    mode_status.hi && mode_status.mid && $stable(mode_status) |=>
      mode_out.emulation && mode_out.rom_enabled &&
      mode_out.cpu_mode == oms_pkg::OMS_CPU_EMULATION)
    else $error("emulation decode wrong");

  // Emulation never reports expansion or single-chip operation.
  a_emul_noext: assert property (
    mode_status.hi && mode_status.mid && $stable(mode_status) |=>
      !mode_out.expansion && !mode_out.single_chip)
    else $error("emulation reports expansion");

  // A reduced-pin part can never reach an emulation mode.
  a_reduced_emul: assert property (
    reduced_pins |-> !mode_out.emulation && mode_out.cpu_mode != oms_pkg::OMS_CPU_EMULATION)
    else $error("emulation on reduced pins");

  // Pin code 0, the one unsupported combination with the top pin low, raises the unsupported flag.
  a_unsup_flag: assert property (
    !is_mode1 && !is_mode23 && !mode_status.hi && $stable(mode_status) |=>
      mode_out.unsupported)
    else $error("unsupported mode not flagged");

  // ----------------------------------------
  // Register assertions
  // ----------------------------------------

  // A missing top pin can never show up in the status.
  a_hi_masked: assert property (
    reduced_pins && $past(reduced_pins) |-> !mode_status.hi)
    else $error("top status bit set on reduced pins");

  // Mode 1 always reads the enable as one.
  a_ext_fixed: assert property (
    setup_read && is_mode1 ##1 psel && penable |-> prdata[oms_pkg::EXT_BIT])
    else $error("extended enable not one in mode 1");

  // A write in modes 2 and 3 lands at the access edge.
  a_ext_write: assert property (
    access_write && is_mode23 |=> extended_enable == $past(pwdata[oms_pkg::EXT_BIT]))
    else $error("extended enable write lost");

  // Any other cycle, including writes in other modes, leaves the enable alone.
  a_ext_guard: assert property (
    !(access_write && is_mode23) |=> $stable(extended_enable))
    else $error("extended enable moved without a write");

  // The enable shown in the access cycle is the one seen at the setup edge.
  a_ext_view: assert property (
    setup_read |=> prdata[oms_pkg::EXT_BIT] == $past(ext_read))
    else $error("extended enable read back wrong");

  // The enable is cleared by reset.
  a_ext_reset: assert property (
    $fell(reset) |-> extended_enable == oms_pkg::EXT_RESET)
    else $error("extended enable not cleared by reset");

  // Reserved bits never read as one.
  a_resv_zero: assert property (
    prdata[oms_pkg::RESV_HI:oms_pkg::RESV_LO] == oms_pkg::RESV_VALUE)
    else $error("reserved bits not zero");

  // Read data falls back to zero outside the access cycle of a read.
  a_idle_data: assert property (
    !setup_read |=> prdata == oms_pkg::RDATA_IDLE)
    else $error("read data left on the bus");

  // A read refreshes the status and returns the same levels.
  a_status_latch: assert property (
    setup_read |=> mode_status == $past(pins_eff) && prdata[2:0] == $past(pins_eff))
    else $error("status not latched on read");

  // The status bits shown in the access cycle are the latched ones.
  a_status_view: assert property (
    setup_read ##1 (psel && penable) |-> prdata[2:0] == mode_status)
    else $error("status view differs from latch");

  // Without a read the status never moves.
  a_status_hold: assert property (
    !setup_read |=> $stable(mode_status))
    else $error("status changed without a read");

  // Leaving reset, the status holds the pins seen at the last reset edge.
  a_reset_load: assert property (
    $fell(reset) |-> mode_status == $past(pins_eff))
    else $error("status not loaded from pins at reset");

  // ----------------------------------------
  // Covers
  // ----------------------------------------

  // Main scenarios: a mode 1 read, an enable write, emulation, single-chip and a bus error.
  c_mode1_read: cover property (setup_read && is_mode1 ##1 psel && penable);
  c_ext_write: cover property (access_write && is_mode23 && pwdata[oms_pkg::EXT_BIT]);
  c_emulation: cover property (mode_out.emulation);
  c_single_chip: cover property (mode_out.single_chip);
  c_unmapped: cover property (pslverr);

endmodule

// [verification/oms_strap_model.sv]
// Board strap model that drives the three mode pins of the device.
`timescale 1ns/1ns
module oms_strap_model (
  // Requested mode number.
  input  wire logic [2:0]       mode_sel,
  // Strap levels seen by the device.
  output oms_pkg::oms_pins_type pins
);
  // Only modes 1, 2, 3, 6 and 7 are ever strapped; anything else falls back to mode 2.
  // The bench changes mode_sel only while reset is held, so the pins never move in operation.
  assign pins = oms_pkg::oms_pins_type'((mode_sel inside {3'h1, 3'h2, 3'h3, 3'h6, 3'h7}) ?
                                        mode_sel : 3'h2);
endmodule

// [verification/tb_operating_mode_select.sv]
// Self-checking testbench for the operating mode select block.
`timescale 1ns/1ns
module tb_operating_mode_select;
  logic                  clk = 1'b0, reset = 1'b1, reduced_pins = 1'b0;
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h0000_0000, prdata, rd;
  logic                  pready, pslverr, err;
  logic [2:0]            mode_sel = 3'h2, m;
  oms_pkg::oms_pins_type pins;
  oms_pkg::oms_mode_type mode_out;
  int                    errors = 0, compares = 0;
  logic [2:0]            modes [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

  // ----------------------------------------
  // Clock, straps and device
  // ----------------------------------------
  initial begin
    forever #10 clk = ~clk;
  end
  oms_strap_model STRAP (.mode_sel(mode_sel), .pins(pins));
  oms_top DUT (.clk(clk), .reset(reset), .mode_pins(pins), .reduced_pins(reduced_pins),
               .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
               .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_out(mode_out));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Straps only move while reset is held, as a real board would guarantee.
  task automatic restart(input logic [2:0] mode, input logic reduced);
    @(posedge clk);
    reset <= 1'b1;
    mode_sel <= mode;
    reduced_pins <= reduced;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
  endtask

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // Read data and response are taken at the very edge that sees pready high.
    rd = prdata;
    err = pslverr;
    chk({31'h0, pready}, 32'h1, "pready never came");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #200000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    foreach (modes[i]) begin
      m = modes[i];
      restart(m, 1'b0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {24'h0, (m == 3'h1), 4'h0, m},
          "status after reset");
      chk({30'h0, mode_out.cpu_mode},
          {30'h0, (m == 3'h3) ? oms_pkg::OMS_CPU_NORMAL :
          (m[2] ? oms_pkg::OMS_CPU_EMULATION : oms_pkg::OMS_CPU_ADVANCED)}, "cpu mode");
      chk({31'h0, mode_out.rom_enabled}, {31'h0, (m != 3'h1)},
          "rom enable");
      chk({31'h0, mode_out.emulation}, {31'h0, m[2]}, "emulation");
      chk({31'h0, mode_out.expansion}, {31'h0, (m == 3'h1)}, "expansion");
      chk({31'h0, mode_out.single_chip}, {31'h0, m[1] & !m[2]}, "single chip");
      chk({31'h0, mode_out.unsupported}, 32'h0, "unsupported");
      apb(1'b1, 12'h000, 32'hffff_ffff);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {24'h0, !m[2], 4'h0, m}, "after write of ones");
      if (!m[2]) chk({31'h0, mode_out.expansion}, 32'h1, "expansion on");
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {24'h0, (m == 3'h1), 4'h0, m}, "after write of zeros");
      if (m[1] && !m[2]) chk({31'h0, mode_out.single_chip}, 32'h1, "single");
      if (m[1] && !m[2]) chk({31'h0, mode_out.expansion}, 32'h0, "expansion off");
    end
    // Reduced-pin part: strap 7 must look like mode 3.
    restart(3'h7, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_0003, "reduced pins status");
    chk({30'h0, mode_out.cpu_mode}, {30'h0, oms_pkg::OMS_CPU_NORMAL}, "reduced cpu");
    chk({31'h0, mode_out.emulation}, 32'h0, "reduced emulation");
    // Unmapped word: error response, no data, no side effect.
    apb(1'b1, 12'h004, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1, "unmapped write error");
    apb(1'b0, 12'h004, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_0003, "status untouched");
    stop_test();
  end
endmodule
